//--- verilog/itm_timer.sv
// Purpose: Programmable interval timer with prescaler, reload and interrupt.
// Assumes: Plain register port; read data appear the cycle after the read strobe.
// Notes:   The counter decrements every scale+1 cycles once enabled.
`timescale 1ns/10ps

// How it works
// - Periodic reloads without software after setup; software clears the sticky status behind each interrupt.
// - Sixteen-bit count decrements once per n cycles.
// - Eight-bit writable scale sets n.
// - Interrupt raised on the strobe that finds the count at one.
// - A strobe at one or zero reloads count from sixteen-bit period.
module itm_timer (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // Register port.
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Interrupt.
   output logic             irq
);

   itm_pkg::itm_req_t   req;          // Bundled bus request.
   itm_pkg::itm_state_t st_r;         // Run state.
   itm_pkg::itm_state_t st_nxt;       // Next run state.
   logic [15:0]         count_r;      // Running count.
   logic [15:0]         count_nxt;    // Next running count.
   logic [7:0]          scale_r;      // Prescale value.
   logic [7:0]          scale_nxt;    // Next prescale value.
   logic [15:0]         period_r;     // Reload period.
   logic [15:0]         period_nxt;   // Next reload period.
   logic                en_r;         // Enable bit.
   logic                en_nxt;       // Next enable bit.
   logic                stat_r;       // Sticky zero status.
   logic                stat_nxt;     // Next sticky status.
   logic                mask_r;       // Interrupt mask.
   logic                mask_nxt;     // Next mask.
   logic [31:0]         rdata_r;      // Read data register.
   logic [31:0]         rdata_nxt;    // Next read data.
   logic                irq_r;        // Registered interrupt.
   logic                irq_nxt;      // Next interrupt.
   logic                tick;         // Decrement strobe from the prescaler.
   logic                zero_evt;     // Strobe found the count at one this cycle.
   logic                scale_wr;     // Scale register written.
   logic                run_now;      // Timer is in the run state.
   logic [8:0]          gap_r;        // Cycles since the last strobe, kept for checking only.
   logic [8:0]          gap_nxt;      // Next strobe gap count.
   logic                armed_r;      // A full interval is being measured.
   logic                armed_nxt;    // Next armed flag.

   assign req.addr  = reg_addr;
   assign req.wdata = reg_wdata;
   assign req.wr    = reg_wr;
   assign req.rd    = reg_rd;

   assign scale_wr = req.wr && (req.addr == itm_pkg::OFF_SCALE);
   // The run state, used by the spacing monitor and the assertions.
   assign run_now  = (st_r == itm_pkg::ST_RUN);

   // Prescaler runs only in the run state.
   // A scale write restarts it, so the interval after a write is counted from the write.
   // The trade-off is that the first interval after the write still uses the old scale.
   itm_prescaler u_pre (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .run     (st_r == itm_pkg::ST_RUN),
      .restart (scale_wr),
      .scale   (scale_r),
      .tick    (tick)
   );

   // The zero event fires on the strobe that finds the count at one and reloads it from the period.
   // A strobe that finds the count already at zero reloads it without an event, so a
   // count of zero left by reset or software does not give a spurious interrupt.
   assign zero_evt = tick && (st_r == itm_pkg::ST_RUN) && (count_r == 16'h0001);

   // Next state of counter, registers and status.
   always_comb begin
      // Registers hold by default; the run state follows the enable and the read data default to zero.
      st_nxt     = st_r;
      count_nxt  = count_r;
      scale_nxt  = scale_r;
      period_nxt = period_r;
      en_nxt     = en_r;
      stat_nxt   = stat_r;
      mask_nxt   = mask_r;
      rdata_nxt  = 32'h0000_0000;
      // Run state follows the enable bit.
      case (st_r)
         itm_pkg::ST_IDLE: begin
            if (en_r) begin
               st_nxt = itm_pkg::ST_RUN;
            end
         end
         itm_pkg::ST_RUN: begin
            if (!en_r) begin
               st_nxt = itm_pkg::ST_IDLE;
            end
         end
         default: begin
            // An illegal state code falls back to idle rather than hanging.
            st_nxt = itm_pkg::ST_IDLE;
         end
      endcase
      // Decrement or reload on each strobe.
      if (tick && st_r == itm_pkg::ST_RUN) begin
         if (count_r <= 16'h0001) begin
            count_nxt = period_r;
         end else begin
            count_nxt = count_r - 16'h0001;
         end
      end
      // Software writes take priority over the counter on the count register.
      if (req.wr) begin
         case (req.addr)
            itm_pkg::OFF_COUNT:  count_nxt  = req.wdata[15:0];
            itm_pkg::OFF_SCALE:  scale_nxt  = req.wdata[7:0];
            itm_pkg::OFF_PERIOD: period_nxt = req.wdata[15:0];
            itm_pkg::OFF_CTRL:   en_nxt     = req.wdata[itm_pkg::CTRL_EN_BIT];
            itm_pkg::OFF_STATUS: begin
               if (req.wdata[itm_pkg::STAT_ZERO_BIT]) begin
                  stat_nxt = 1'b0;
               end
            end
            itm_pkg::OFF_MASK:   mask_nxt   = req.wdata[0];
            default: begin
               mask_nxt = mask_r;
            end
         endcase
      end
      // A new zero event wins over a clear in the same cycle.
      if (zero_evt) begin
         stat_nxt = 1'b1;
      end
      // Read data for the next cycle; unmapped addresses read zero.
      // The data stand for exactly one cycle and are zero otherwise, so the port
      // needs no separate valid signal.
      if (req.rd) begin
         case (req.addr)
            itm_pkg::OFF_COUNT:  rdata_nxt = {16'h0000, count_r};
            itm_pkg::OFF_SCALE:  rdata_nxt = {24'h000000, scale_r};
            itm_pkg::OFF_PERIOD: rdata_nxt = {16'h0000, period_r};
            itm_pkg::OFF_CTRL:   rdata_nxt = {31'h00000000, en_r};
            itm_pkg::OFF_STATUS: rdata_nxt = {31'h00000000, stat_r};
            itm_pkg::OFF_MASK:   rdata_nxt = {31'h00000000, mask_r};
            default:             rdata_nxt = 32'h0000_0000;
         endcase
      end
      irq_nxt = stat_nxt && mask_nxt;
   end

   // Register all state.
   // Status and interrupt load from the same next values, so the line never lags the status.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r     <= itm_pkg::ST_IDLE;
         count_r  <= itm_pkg::RST_COUNT;
         scale_r  <= itm_pkg::RST_SCALE;
         period_r <= itm_pkg::RST_PERIOD;
         en_r     <= itm_pkg::RST_EN;
         stat_r   <= itm_pkg::RST_STATUS;
         mask_r   <= itm_pkg::RST_MASK;
         rdata_r  <= 32'h0000_0000;
         irq_r    <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         count_r  <= count_nxt;
         scale_r  <= scale_nxt;
         period_r <= period_nxt;
         en_r     <= en_nxt;
         stat_r   <= stat_nxt;
         mask_r   <= mask_nxt;
         rdata_r  <= rdata_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq       = irq_r;

   // Strobe spacing monitor. It measures the distance between two strobes so that the
   // assertions below can hold it against the scale register; a scale write or a stop
   // disarms it, because the first strobe after either is not a full interval.
   always_comb begin
      gap_nxt   = gap_r;
      armed_nxt = armed_r;
      if (tick) begin
         gap_nxt = 9'h001;
      end else if (gap_r != 9'h1FF) begin
         gap_nxt = gap_r + 9'h001; // Saturates, so a stalled prescaler never wraps to a match.
      end
      if (!run_now || scale_wr) begin
         armed_nxt = 1'b0;
      end else if (tick) begin
         armed_nxt = 1'b1;
      end
   end

   // Register the spacing monitor.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gap_r   <= 9'h000;
         armed_r <= 1'b0;
      end else begin
         gap_r   <= gap_nxt;
         armed_r <= armed_nxt;
      end
   end

   // Assertions.
   // They watch the registers that the logic above drives; bus inputs pick the cycles
   // in which a rule applies, and write data also stand in consequents through $past.
   a_reload_period: assert property (@(posedge sys_clk) disable iff (!nrst)
      (zero_evt && !req.wr) |=> (count_r == $past(period_r)))
      else $error("count not reloaded from period");
   a_decrement_one: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tick && st_r == itm_pkg::ST_RUN && count_r > 16'h0001 && !req.wr)
      |=> (count_r == $past(count_r) - 16'h0001))
      else $error("count did not decrement by one");
   a_hold_no_tick: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!tick && !req.wr) |=> (count_r == $past(count_r)))
      else $error("count moved without a strobe");
   a_zero_status: assert property (@(posedge sys_clk) disable iff (!nrst)
      zero_evt |=> stat_r)
      else $error("zero event did not set status");
   a_irq_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
      (stat_r && mask_r) |-> irq)
      else $error("interrupt not raised for unmasked status");
   a_scale_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      (req.wr && req.addr == itm_pkg::OFF_SCALE) |=> (scale_r == $past(req.wdata[7:0])))
      else $error("scale write lost");
   a_run_enable: assert property (@(posedge sys_clk) disable iff (!nrst)
      en_r |=> ##[0:1] (st_r == itm_pkg::ST_RUN) || !en_r)
      else $error("timer did not start when enabled");
   a_read_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
      (req.rd && req.addr > itm_pkg::OFF_MASK) |=> (reg_rdata == 32'h0000_0000))
      else $error("unmapped read not zero");

   // A masked or cleared status keeps the line low.
   a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(stat_r && mask_r) |-> !irq)
      else $error("interrupt raised without unmasked status");

   // Two strobes in a row are exactly scale plus one cycles apart.
   a_tick_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tick && armed_r) |-> (gap_r == ({1'b0, scale_r} + 9'h001)))
      else $error("decrement strobe spacing wrong");

   // Once a full interval has passed, the strobe is due in that very cycle.
   a_tick_due: assert property (@(posedge sys_clk) disable iff (!nrst)
      (armed_r && gap_r == ({1'b0, scale_r} + 9'h001)) |-> tick)
      else $error("decrement strobe missing");

   // While idle only a software write may move the count.
   a_idle_frozen: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!run_now && !req.wr) |=> (count_r == $past(count_r)))
      else $error("count moved while idle");

   // The status bit is set by a zero event and by nothing else.
   a_zero_only: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!stat_r && !zero_evt) |=> !stat_r)
      else $error("status set without zero event");

   // A strobe at a count of zero reloads the period without an event.
   a_zero_silent: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tick && run_now && count_r == 16'h0000 && !req.wr)
      |=> (count_r == $past(period_r)) && (stat_r == $past(stat_r)))
      else $error("zero count not reloaded silently");

   // Writing one to the status bit clears it unless an event lands in the same cycle.
   a_status_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      (req.wr && req.addr == itm_pkg::OFF_STATUS && req.wdata[itm_pkg::STAT_ZERO_BIT] && !zero_evt)
      |=> !stat_r)
      else $error("status not cleared by write");

   // The run state is always one of the two one-hot codes.
   a_state_onehot: assert property (@(posedge sys_clk) disable iff (!nrst)
      $onehot(st_r))
      else $error("run state code illegal");

   // Clearing the enable stops the timer on the next edge.
   a_stop_disable: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!en_r && run_now) |=> !run_now)
      else $error("timer kept running when disabled");

   // A software write to the count wins over a strobe in the same cycle.
   a_count_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      (req.wr && req.addr == itm_pkg::OFF_COUNT) |=> (count_r == $past(req.wdata[15:0])))
      else $error("count write lost");

   // A period write lands in full.
   a_period_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      (req.wr && req.addr == itm_pkg::OFF_PERIOD) |=> (period_r == $past(req.wdata[15:0])))
      else $error("period write lost");

   // A read of the count returns the value that stood at the read strobe.
   a_read_count: assert property (@(posedge sys_clk) disable iff (!nrst)
      (req.rd && req.addr == itm_pkg::OFF_COUNT) |=> (reg_rdata == {16'h0000, $past(count_r)}))
      else $error("count read wrong");

endmodule

//--- verilog/itm_pkg.sv
// Purpose: Shared constants and types for the interval timer.
// Assumes: A plain register port with 32-bit write data and byte-free word access.
// Notes:   Register offsets are word indices on the plain port.
package itm_pkg;

   // Register address width of the plain port.
   localparam int ADDR_W = 4;

   // Register offsets.
   localparam logic [3:0] OFF_COUNT   = 4'h0;
   localparam logic [3:0] OFF_SCALE   = 4'h1;
   localparam logic [3:0] OFF_PERIOD  = 4'h2;
   localparam logic [3:0] OFF_CTRL    = 4'h3;
   localparam logic [3:0] OFF_STATUS  = 4'h4;
   localparam logic [3:0] OFF_MASK    = 4'h5;

   // Field positions.
   localparam int CTRL_EN_BIT    = 0;
   localparam int STAT_ZERO_BIT  = 0;

   // Reset values.
   localparam logic [15:0] RST_COUNT  = 16'h0000;
   localparam logic [7:0]  RST_SCALE  = 8'h00;
   localparam logic [15:0] RST_PERIOD = 16'h0000;
   localparam logic        RST_EN     = 1'b0;
   localparam logic        RST_STATUS = 1'b0;
   localparam logic        RST_MASK   = 1'b0;

   // Timer run states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } itm_state_t;

   // Register bus request bundle.
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } itm_req_t;

endpackage

//--- verilog/itm_prescaler.sv
// Purpose: Cycle counter that emits one strobe every scale+1 enabled cycles.
// Assumes: Single clock sys_clk, asynchronous active-low reset.
// Notes:   Restarting on a scale write keeps the first period predictable.
`timescale 1ns/10ps
module itm_prescaler (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Control.
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [7:0] scale,
   // Output strobe.
   output logic            tick
);

   logic [7:0] cnt_r;    // Cycles left before the next strobe.
   logic [7:0] cnt_nxt;  // Next value of the cycle counter.
   logic       tick_r;   // Registered strobe.
   logic       tick_nxt; // Next value of the strobe.

   // Count down and reload from the scale value on expiry.
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (!run || restart) begin
         cnt_nxt = scale;
      end else if (cnt_r == 8'h00) begin
         cnt_nxt  = scale;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r - 8'h01;
      end
   end

   // Register the prescaler state.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r  <= 8'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

   // A strobe is followed by at least one quiet cycle while running with a nonzero scale.
   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tick && run && !restart && scale != 8'h00) |=> !tick)
      else $error("prescaler strobes too close together");

endmodule

//--- tb/itm_timer_tb.sv
// Purpose: Self-checking bench for the interval timer.
// Assumes: Registers at the package offsets; read data stand one cycle after the strobe.
// Notes:   Periods are measured from one interrupt rise to the next.
`timescale 1ns/10ps
module itm_timer_tb;
   logic        sys_clk;     // Bench clock.
   logic        nrst;        // Active-low reset.
   logic [3:0]  reg_addr;    // Register index.
   logic [31:0] reg_wdata;   // Write data.
   logic        reg_wr;      // Write strobe.
   logic        reg_rd;      // Read strobe.
   logic [31:0] reg_rdata;   // Read data.
   logic        irq;         // Interrupt level.
   int          mismatches;  // Failed comparisons.
   int          checks;      // Comparisons made.

   // Device under test.
   itm_timer u_dut (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .irq       (irq)
   );

   // Clock at 100 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One write; a free cycle follows so a strobe is never set twice in one time step.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      @(posedge sys_clk);
   endtask

   // One read; the data are taken at the edge that ends their only valid cycle.
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(posedge sys_clk);
      chk(reg_rdata, exp);
   endtask

   // Waits for an interrupt level under a bounded count, then checks it.
   task automatic wait_irq(input logic lvl, input int lim);
      int n;
      n = 0;
      while (irq !== lvl && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk({31'h0, irq}, {31'h0, lvl});
   endtask

   // Reset values, including an unmapped index that must read zero.
   task automatic t_reset();
      for (int a = 0; a < 6; a++) rchk(4'(a), 32'h0);
      rchk(4'hF, 32'h0);
   endtask

   // Count, scale and period keep only their own widths; unmapped writes leave nothing behind.
   task automatic t_regs();
      wr(itm_pkg::OFF_COUNT, 32'hFFFF_A5C3);
      wr(itm_pkg::OFF_SCALE, 32'h1234_56FF);
      wr(itm_pkg::OFF_PERIOD, 32'hFFFF_1234);
      wr(4'hE, 32'hFFFF_FFFF);
      rchk(itm_pkg::OFF_COUNT, 32'h0000_A5C3);
      rchk(itm_pkg::OFF_SCALE, 32'h0000_00FF);
      rchk(itm_pkg::OFF_PERIOD, 32'h0000_1234);
      rchk(4'hE, 32'h0000_0000);
   endtask

   // Interrupts repeat every period times scale plus one cycles with no reprogramming.
   task automatic t_period(input int s, input int p);
      time t0;
      wr(itm_pkg::OFF_CTRL, 32'h0);
      wr(itm_pkg::OFF_STATUS, 32'h1);
      wr(itm_pkg::OFF_SCALE, 32'(s));
      wr(itm_pkg::OFF_PERIOD, 32'(p));
      wr(itm_pkg::OFF_COUNT, 32'h2);
      wr(itm_pkg::OFF_MASK, 32'h1);
      wr(itm_pkg::OFF_CTRL, 32'h1);
      wait_irq(1'b1, 2000);
      t0 = $time;
      wr(itm_pkg::OFF_STATUS, 32'h1);
      wait_irq(1'b0, 20);
      wait_irq(1'b1, 2000);
      chk(32'(($time - t0) / 10), 32'(p * (s + 1)));
   endtask

   // Starting from a count of zero, the first strobe reloads silently and later events set status.
   // A masked event stays silent but sticky; unmasking raises the line, a write of one clears it.
   task automatic t_mask();
      wr(itm_pkg::OFF_CTRL, 32'h0);
      wr(itm_pkg::OFF_STATUS, 32'h1);
      wr(itm_pkg::OFF_MASK, 32'h0);
      wr(itm_pkg::OFF_SCALE, 32'h0);
      wr(itm_pkg::OFF_PERIOD, 32'h3);
      wr(itm_pkg::OFF_COUNT, 32'h0);
      wr(itm_pkg::OFF_CTRL, 32'h1);
      repeat (10) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      wr(itm_pkg::OFF_CTRL, 32'h0);
      rchk(itm_pkg::OFF_STATUS, 32'h1);
      wr(itm_pkg::OFF_MASK, 32'h1);
      wait_irq(1'b1, 4);
      wr(itm_pkg::OFF_STATUS, 32'h1);
      wait_irq(1'b0, 4);
      rchk(itm_pkg::OFF_STATUS, 32'h0);
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence: reset for 16 cycles, then every scenario in turn.
   initial begin
      nrst       = 1'b0;
      reg_addr   = 4'h0;
      reg_wdata  = 32'h0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      mismatches = 0;
      checks     = 0;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_regs();
      t_period(0, 6);
      t_period(2, 4);
      t_mask();
      end_sim();
   end

   // Watchdog: the scenarios need well under 1000 cycles, so 100 us means a hang.
   initial begin
      #100us;
      mismatches++;
      end_sim();
   end
endmodule
